// >>> design/isc_pkg.sv
package isc_pkg;
  // -------------------------------------------------------------
  // sizes
  // -------------------------------------------------------------
  localparam int NUM_SRC = 32;
  localparam int SRC_W = 5;
  localparam int PRIO_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SYS_W = 8;
  localparam int EXT_W = 4;
  localparam int EXT_BASE = 28;

  // -------------------------------------------------------------
  // register offsets (byte addresses)
  // -------------------------------------------------------------
  localparam logic [7:0] SMR_BASE = 8'h00;
  localparam logic [7:0] VECTOR_OFS = 8'h80;
  localparam logic [7:0] FAST_VECTOR_OFS = 8'h84;
  localparam logic [7:0] CURRENT_NUM_OFS = 8'h88;
  localparam logic [7:0] PENDING_OFS = 8'h8c;
  localparam logic [7:0] MASK_OFS = 8'h90;
  localparam logic [7:0] CORE_STATUS_OFS = 8'h94;
  localparam logic [7:0] ENABLE_CMD_OFS = 8'ha0;
  localparam logic [7:0] DISABLE_CMD_OFS = 8'ha4;
  localparam logic [7:0] CLEAR_CMD_OFS = 8'ha8;
  localparam logic [7:0] SET_CMD_OFS = 8'hac;
  localparam logic [7:0] END_CMD_OFS = 8'hb0;
  localparam logic [7:0] FORCE_OFS = 8'hb4;
  localparam logic [7:0] CONTROL_OFS = 8'hb8;

  // -------------------------------------------------------------
  // source mode fields: bits 2:0 priority, bits 6:5 trigger type
  // -------------------------------------------------------------
  localparam int PRIO_LSB = 0;
  localparam int TRIG_LSB = 5;
  localparam int CTRL_GMASK_BIT = 1;
  localparam logic [1:0] TRIG_LEVEL_ACT = 2'h0; // internal level, ext low level
  localparam logic [1:0] TRIG_EDGE_ACT = 2'h1; // internal edge, ext falling edge
  localparam logic [1:0] TRIG_LEVEL_HI = 2'h2; // high level
  localparam logic [1:0] TRIG_EDGE_RISE = 2'h3; // rising edge
  localparam logic [1:0] TRIG_RESET = 2'h0;
  localparam logic [2:0] PRIO_RESET = 3'h0;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
endpackage

// >>> design/isc_stack.sv
// small memory holding the nested current number and level
module isc_stack
  import isc_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = SRC_W + PRIO_W
)
(
  input wire logic clock_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  // -------------------------------------------------------------
  // storage
  // -------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH]; // entries, not reset: validity tracked by depth counter

  // registered read port keeps the caller's timing deterministic
  always_ff @(posedge clock_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule

// >>> design/isc_top.sv
// Behaviour
// - always clocked, no power management gating
// - request outputs also act as wakeup
// - global mask wakes without driving normal request; fast request still driven
// - source 0 comes from fast pin
// - source 1 is OR of system lines
// - sources 2..31 peripheral or external lines
// - peripheral id equals source number
// - per-source mode register selects trigger
// - internal sources level or edge only
// - external sources four trigger conditions
// - write-one enable/disable, readable mask
// - disabled source never affects others
// - set forces pending, clear drops edge
// - set/clear ignored on level sources
// - vector read clears current edge only
// - no auto clear for fast forced source
// - source 0 cleared on fast vector read
// - pending shows activity regardless of mask
// - status returns current source number
// - core status mirrors request outputs
// - pin inputs pass a two-stage synchroniser
// - priority 0..7, ties to lowest number
// - vector read deasserts normal request
// - eight-entry nesting stack
//
// The address-and-strobe port and the register addresses were decided locally.
module isc_top
  import isc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic fast_irq_pin_i,
  input wire logic [isc_pkg::SYS_W-1:0] system_source_i,
  input wire logic [isc_pkg::EXT_BASE-1:2] periph_id_n_i,
  input wire logic [isc_pkg::EXT_W-1:0] ext_irq_pins_i,
  input wire logic [isc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [isc_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [isc_pkg::DATA_W-1:0] rdata_o,
  output logic normal_req_n_o,
  output logic fast_req_n_o,
  output logic wakeup_o
);
  import isc_pkg::*;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic [NUM_SRC-1:0] ext_s1; // first synchroniser stage
    logic [NUM_SRC-1:0] ext_s2; // second synchroniser stage
    logic [NUM_SRC-1:0] prev; // previous raw level for edge detect
    logic [NUM_SRC-1:0] edge_lat; // latched edges
    logic [NUM_SRC-1:0] mask; // enables
    logic [NUM_SRC-1:0] force_fast; // fast forcing selects
    logic [NUM_SRC*2-1:0] trig; // trigger type per source
    logic [NUM_SRC*3-1:0] prio; // priority per source
    logic [SRC_W-1:0] cur_num; // current interrupt number
    logic [PRIO_W-1:0] cur_lvl; // current level
    logic [3:0] depth; // nesting depth
    logic gmask; // global request mask
    logic nreq_n; // normal request, active low
    logic freq_n; // fast request, active low
    logic wake; // wakeup, held high while any candidate is present
    logic rd_pend; // read data pending from stack
    logic [DATA_W-1:0] rdata; // read data
  } isc_state_t;

  isc_state_t st_q;
  isc_state_t st_d;

  logic [NUM_SRC-1:0] raw; // per-source input level before trigger logic
  logic [NUM_SRC-1:0] is_ext; // sources wired to pins
  logic [NUM_SRC-1:0] active; // level/edge condition per source
  logic [NUM_SRC-1:0] pend; // pending image
  logic [NUM_SRC-1:0] is_edge; // trigger is edge
  logic [SRC_W-1:0] win_num; // arbitration winner
  logic [PRIO_W-1:0] win_lvl; // winner level
  logic win_vld; // any normal candidate
  logic [SRC_W+PRIO_W-1:0] stk_rdata; // popped entry
  logic stk_we; // push strobe
  logic [2:0] stk_waddr; // push address
  logic [2:0] stk_raddr; // address of the entry under the top of stack

  // -------------------------------------------------------------
  // input stage
  // -------------------------------------------------------------
  // source 0 from the fast pin, 1 from the system OR, pins on the top sources
  always_comb
  begin
    raw = '0;
    raw[0] = st_q.ext_s2[0];
    raw[1] = |system_source_i;
    raw[EXT_BASE-1:2] = periph_id_n_i;
    raw[NUM_SRC-1:EXT_BASE] = st_q.ext_s2[NUM_SRC-1:EXT_BASE];
    is_ext = '0;
    is_ext[0] = 1'b1;
    is_ext[NUM_SRC-1:EXT_BASE] = '1;
  end

  // per-source trigger decode
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : gen_src
      logic [1:0] tt;
      logic lvl;
      assign tt = st_q.trig[g*2 +: 2];
      // internal sources ignore the polarity bit; it is handled internally
      assign lvl = (is_ext[g] && !tt[1]) ? !raw[g] : raw[g];
      assign is_edge[g] = tt[0];
      assign active[g] = is_edge[g] ? st_q.edge_lat[g] : lvl;
      assign pend[g] = active[g];
    end
  endgenerate

  // -------------------------------------------------------------
  // priority arbitration over enabled, non-forced sources 1..31
  // -------------------------------------------------------------
  always_comb
  begin
    win_num = '0;
    win_lvl = '0;
    win_vld = 1'b0;
    for (int i = NUM_SRC - 1; i >= 1; i--)
    begin
      // masked sources are excluded here so they never steal service
      if (pend[i] && st_q.mask[i] && !st_q.force_fast[i])
      begin
        // descending scan with >= lets the lowest number win ties
        if (!win_vld || st_q.prio[i*3 +: 3] >= win_lvl)
        begin
          win_num = SRC_W'(i);
          win_lvl = st_q.prio[i*3 +: 3];
          win_vld = 1'b1;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb
  begin
    logic wr_vec;
    logic rd_vec;
    logic rd_fvec;
    logic fast_cand;
    logic norm_cand;
    logic [NUM_SRC-1:0] edge_now;
    logic [NUM_SRC-1:0] clr;
    logic [NUM_SRC-1:0] setb;
    logic [4:0] idx;
    st_d = st_q;
    fast_cand = 1'b0;
    norm_cand = 1'b0;
    edge_now = '0;
    wr_vec = 1'b0;
    rd_vec = rd_i && (addr_i == VECTOR_OFS);
    rd_fvec = rd_i && (addr_i == FAST_VECTOR_OFS);
    clr = '0;
    setb = '0;
    idx = addr_i[6:2];
    stk_we = 1'b0;
    stk_waddr = st_q.depth[2:0];
    // a pop restores the entry under the top one, so address it before the pop lands
    stk_raddr = 3'(st_q.depth - 4'h2);
    st_d.rd_pend = 1'b0;

    // pin synchronisers; only stage two is read by logic
    st_d.ext_s1[0] = fast_irq_pin_i;
    st_d.ext_s1[NUM_SRC-1:EXT_BASE] = ext_irq_pins_i;
    st_d.ext_s2 = st_q.ext_s1;
    st_d.prev = raw;

    // edge detection follows the selected polarity
    for (int i = 0; i < NUM_SRC; i++)
    begin
      edge_now[i] = (is_ext[i] && !st_q.trig[i*2+1]) ? (st_q.prev[i] && !raw[i])
                                                     : (!st_q.prev[i] && raw[i]);
    end

    // register writes
    if (wr_i)
    begin
      if (addr_i < VECTOR_OFS)
      begin
        st_d.prio[idx*3 +: 3] = wdata_i[PRIO_LSB +: PRIO_W];
        st_d.trig[idx*2 +: 2] = wdata_i[TRIG_LSB +: 2];
      end
      case (addr_i)
        ENABLE_CMD_OFS: st_d.mask = st_q.mask | wdata_i;
        DISABLE_CMD_OFS: st_d.mask = st_q.mask & ~wdata_i;
        SET_CMD_OFS: setb = wdata_i;
        CLEAR_CMD_OFS: clr = wdata_i;
        FORCE_OFS: st_d.force_fast = wdata_i;
        CONTROL_OFS: st_d.gmask = wdata_i[CTRL_GMASK_BIT];
        END_CMD_OFS:
        begin
          // pop restores the interrupted number and level
          wr_vec = 1'b1;
          if (st_q.depth != 4'h0)
          begin
            st_d.depth = st_q.depth - 4'h1;
            st_d.rd_pend = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // restored entry lands one cycle after the pop
    if (st_q.rd_pend)
    begin
      if (st_q.depth != 4'h0)
      begin
        st_d.cur_num = stk_rdata[SRC_W+PRIO_W-1:PRIO_W];
        st_d.cur_lvl = stk_rdata[PRIO_W-1:0];
      end
      else
      begin
        st_d.cur_num = '0;
        st_d.cur_lvl = '0;
      end
    end

    // vector read takes the winner, pushes it and clears its edge
    if (rd_vec && win_vld)
    begin
      st_d.cur_num = win_num;
      st_d.cur_lvl = win_lvl;
      if (st_q.depth < 4'(STACK_DEPTH))
      begin
        stk_we = 1'b1;
        stk_waddr = st_q.depth[2:0];
        st_d.depth = st_q.depth + 4'h1;
      end
      if (!st_q.force_fast[win_num])
      begin
        clr[win_num] = 1'b1;
      end
    end
    if (rd_fvec)
    begin
      clr[0] = 1'b1;
    end

    // edge latch: set and new edges beat any clear in the same cycle
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (is_edge[i])
      begin
        if (edge_now[i] || setb[i])
        begin
          st_d.edge_lat[i] = 1'b1;
        end
        else if (clr[i])
        begin
          st_d.edge_lat[i] = 1'b0;
        end
      end
      else
      begin
        st_d.edge_lat[i] = 1'b0;
      end
    end

    // request generation; the normal line waits for a higher level when nested
    fast_cand = (pend[0] && st_q.mask[0]) || |(pend & st_q.mask & st_q.force_fast);
    norm_cand = win_vld && (st_q.depth == 4'h0 || win_lvl > st_q.cur_lvl);
    st_d.freq_n = !fast_cand;
    if (rd_vec)
    begin
      st_d.nreq_n = 1'b1;
    end
    else
    begin
      st_d.nreq_n = !(norm_cand && !st_q.gmask);
    end
    // wake on any candidate even when the global mask holds the line
    st_d.wake = fast_cand || norm_cand;

    // read data
    st_d.rdata = '0;
    if (rd_i)
    begin
      if (addr_i < VECTOR_OFS)
      begin
        st_d.rdata[PRIO_LSB +: PRIO_W] = st_q.prio[idx*3 +: 3];
        st_d.rdata[TRIG_LSB +: 2] = st_q.trig[idx*2 +: 2];
      end
      case (addr_i)
        VECTOR_OFS: st_d.rdata = DATA_W'(win_num);
        FAST_VECTOR_OFS: st_d.rdata = '0;
        CURRENT_NUM_OFS: st_d.rdata = DATA_W'(st_q.cur_num);
        PENDING_OFS: st_d.rdata = pend;
        MASK_OFS: st_d.rdata = st_q.mask;
        CORE_STATUS_OFS: st_d.rdata = {30'h0, !st_q.nreq_n, !st_q.freq_n};
        FORCE_OFS: st_d.rdata = st_q.force_fast;
        CONTROL_OFS: st_d.rdata[CTRL_GMASK_BIT] = st_q.gmask;
        default: ;
      endcase
    end
    if (wr_vec)
    begin
      st_d.rdata = '0;
    end
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  // free-running clock, never gated by power management
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
      st_q.nreq_n <= 1'b1;
      st_q.freq_n <= 1'b1;
      st_q.mask <= MASK_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // nesting stack
  isc_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(SRC_W + PRIO_W)
  ) u_stack (
    .clock_i(clock_i),
    .we_i(stk_we),
    .waddr_i(stk_waddr),
    .wdata_i({st_d.cur_num, st_d.cur_lvl}),
    .raddr_i(stk_raddr),
    .rdata_o(stk_rdata)
  );

  assign rdata_o = st_q.rdata;
  assign normal_req_n_o = st_q.nreq_n;
  assign fast_req_n_o = st_q.freq_n;
  assign wakeup_o = st_q.wake;
endmodule

// >>> verification/isc_core_model.sv
// -------------------------------------------------------------
// processor core model: idle state left on any wake event
// -------------------------------------------------------------
module isc_core_model
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sleep_i, // bench puts the core to idle
  input wire logic normal_req_n_i,
  input wire logic fast_req_n_i,
  input wire logic wakeup_i,
  output logic idle_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // either request or the bare wake line ends idle; wake beats sleep
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      idle_o <= 1'b0;
    else if (!normal_req_n_i || !fast_req_n_i)
      idle_o <= 1'b0;
    else if (wakeup_i)
      idle_o <= 1'b0;
    else if (sleep_i)
      idle_o <= 1'b1;
  end
endmodule

// >>> verification/isc_top_asserts.sv
// -------------------------------------------------------------
// port level checks of the source control block
// -------------------------------------------------------------
module isc_top_asserts
  import isc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [isc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [isc_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [isc_pkg::DATA_W-1:0] rdata_o,
  input wire logic normal_req_n_o,
  input wire logic fast_req_n_o,
  input wire logic wakeup_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // read data only in the cycle after a read strobe
  read_idle_zero_a: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data not zero outside a read");
  vec_drops_req_a: assert property (rd_i && addr_i == VECTOR_OFS |=> normal_req_n_o)
    else $error("normal request stays after vector read");
  core_image_a: assert property (rd_i && addr_i == CORE_STATUS_OFS |=>
    rdata_o[1:0] == {!$past(normal_req_n_o), !$past(fast_req_n_o)})
    else $error("core status differs from request lines");
  wake_on_req_a: assert property (!normal_req_n_o || !fast_req_n_o |-> wakeup_o)
    else $error("request without wake");
  enable_mask_a: assert property (wr_i && addr_i == ENABLE_CMD_OFS ##1 !wr_i ##1
    rd_i && addr_i == MASK_OFS |=> (rdata_o & $past(wdata_i, 3)) == $past(wdata_i, 3))
    else $error("enabled bits missing from mask");
  disable_mask_a: assert property (wr_i && addr_i == DISABLE_CMD_OFS ##1 !wr_i ##1
    rd_i && addr_i == MASK_OFS |=> (rdata_o & $past(wdata_i, 3)) == '0)
    else $error("disabled bits left in mask");
  fast_vec_zero_a: assert property (rd_i && addr_i == FAST_VECTOR_OFS |=> rdata_o == '0)
    else $error("fast vector not zero");
  current_num_a: assert property (rd_i && addr_i == VECTOR_OFS ##1
    rd_i && addr_i == CURRENT_NUM_OFS |=> rdata_o == $past(rdata_o))
    else $error("current number differs from vector");
  vec_cov_c: cover property (rd_i && addr_i == VECTOR_OFS ##[1:3] !normal_req_n_o);
  fast_cov_c: cover property (!fast_req_n_o);
  gmask_cov_c: cover property (wakeup_o && normal_req_n_o && fast_req_n_o);
endmodule

bind isc_top isc_top_asserts chk_i (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .normal_req_n_o, .fast_req_n_o, .wakeup_o);

// >>> verification/isc_top_tb.sv
// -------------------------------------------------------------
// register level tests of the source control block
// -------------------------------------------------------------
module isc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import isc_pkg::*;
  logic clock_i = 0, rst_i = 1, fast_irq_pin_i = 0, wr_i = 0, rd_i = 0, sleep = 0;
  logic [SYS_W-1:0] system_source_i = '0;
  logic [EXT_BASE-1:2] periph_id_n_i = '0;
  logic [EXT_W-1:0] ext_irq_pins_i = '0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0, rdata_o, rv, v1;
  logic normal_req_n_o, fast_req_n_o, wakeup_o, core_idle;
  logic [3:0] hi_exp = 4'b1100, lo_exp = 4'b1011; // per trigger type 3..0
  int n_mismatch = 0, n_compared = 0;
  initial forever #5 clock_i = ~clock_i;
  isc_top uut (.clock_i, .rst_i, .fast_irq_pin_i, .system_source_i, .periph_id_n_i,
    .ext_irq_pins_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .normal_req_n_o,
    .fast_req_n_o, .wakeup_o);
  isc_core_model core (.clock_i, .rst_i, .sleep_i(sleep), .normal_req_n_i(normal_req_n_o),
    .fast_req_n_i(fast_req_n_o), .wakeup_i(wakeup_o), .idle_o(core_idle));
  // source mode word: trigger in 6:5, priority in 2:0
  function automatic logic [31:0] md(input logic [1:0] t, input logic [2:0] p);
    md = {25'h0, t, 2'h0, p};
  endfunction
  // one cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // data looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog: the tests need a few hundred cycles at most
  initial
  begin
    #200us;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(MASK_OFS, rv); chk("mask reset", MASK_RESET, rv);
    rd(SMR_BASE, rv); chk("mode reset", 32'h0, rv);
    rd(8'hfc, rv); chk("unmapped", 32'h0, rv);
    // enable and disable in one write each
    wr(ENABLE_CMD_OFS, 32'h6); rd(MASK_OFS, rv); chk("mask on", 32'h6, rv);
    wr(DISABLE_CMD_OFS, 32'h4); rd(MASK_OFS, rv); chk("mask off", 32'h2, rv);
    $display("test enable done");
    // system line level source through vector and current number
    system_source_i <= 8'h10;
    repeat (3) @(posedge clock_i);
    chk("normal req", 32'h0, normal_req_n_o);
    rd(PENDING_OFS, rv); chk("pending sys", 32'h1, rv[1]);
    rd(CORE_STATUS_OFS, rv); chk("core status", 32'h2, rv[1:0]);
    @(posedge clock_i);
    addr_i <= VECTOR_OFS;
    rd_i <= 1'b1;
    @(posedge clock_i);
    addr_i <= CURRENT_NUM_OFS;
    #1 v1 = rdata_o;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
    chk("vector", 32'h1, v1);
    chk("current", 32'h1, rv);
    chk("req after vector", 32'h1, normal_req_n_o);
    system_source_i <= 8'h0;
    wr(END_CMD_OFS, 32'h0);
    $display("test system source done");
    // internal edge latch, clear and set; level source ignores set
    wr(SMR_BASE + 8'h0c, md(TRIG_EDGE_ACT, 3'h0));
    periph_id_n_i[3] <= 1'b1;
    repeat (2) @(posedge clock_i);
    periph_id_n_i[3] <= 1'b0;
    repeat (3) @(posedge clock_i);
    rd(PENDING_OFS, rv); chk("edge latched", 32'h1, rv[3]);
    wr(CLEAR_CMD_OFS, 32'h8); rd(PENDING_OFS, rv); chk("cleared", 32'h0, rv[3]);
    wr(SET_CMD_OFS, 32'h8); rd(PENDING_OFS, rv); chk("set", 32'h1, rv[3]);
    wr(SET_CMD_OFS, 32'h4); rd(PENDING_OFS, rv); chk("level set", 32'h0, rv[2]);
    // equal priorities: lowest number wins, only it is cleared
    wr(SMR_BASE + 8'h10, md(TRIG_EDGE_ACT, 3'h4));
    wr(SMR_BASE + 8'h14, md(TRIG_EDGE_ACT, 3'h4));
    wr(ENABLE_CMD_OFS, 32'h30);
    wr(SET_CMD_OFS, 32'h30);
    repeat (3) @(posedge clock_i);
    rd(VECTOR_OFS, rv); chk("tie winner", 32'h4, rv);
    rd(PENDING_OFS, rv); chk("auto clear", 32'h5, rv[5:3]);
    wr(END_CMD_OFS, 32'h0);
    wr(CLEAR_CMD_OFS, 32'h20);
    // nesting: a higher level interrupts, the pop restores the outer number
    wr(SMR_BASE + 8'h14, md(TRIG_EDGE_ACT, 3'h6));
    wr(SET_CMD_OFS, 32'h10);
    rd(VECTOR_OFS, rv); chk("outer vector", 32'h4, rv);
    wr(SET_CMD_OFS, 32'h20);
    rd(CORE_STATUS_OFS, rv); chk("nested req", 32'h1, rv[1]);
    rd(VECTOR_OFS, rv); chk("inner vector", 32'h5, rv);
    wr(END_CMD_OFS, 32'h0);
    rd(CURRENT_NUM_OFS, rv); chk("restored", 32'h4, rv);
    wr(END_CMD_OFS, 32'h0);
    rd(CURRENT_NUM_OFS, rv); chk("unnested", 32'h0, rv);
    // fast forcing: no normal winner, no auto clear, fast line driven
    wr(FORCE_OFS, 32'h20);
    wr(SET_CMD_OFS, 32'h20);
    rd(VECTOR_OFS, rv); chk("forced vector", 32'h0, rv);
    rd(PENDING_OFS, rv); chk("forced kept", 32'h1, rv[5]);
    chk("forced fast", 32'h0, fast_req_n_o);
    wr(FORCE_OFS, 32'h0);
    wr(CLEAR_CMD_OFS, 32'h20);
    $display("test edge sources done");
    // external pin: each trigger type after a rise and after a fall
    for (int t = 0; t < 4; t++)
    begin
      wr(SMR_BASE + 8'h70, md(t[1:0], 3'h0));
      wr(CLEAR_CMD_OFS, 32'h1000_0000);
      ext_irq_pins_i[0] <= 1'b1;
      repeat (5) @(posedge clock_i);
      rd(PENDING_OFS, rv); chk("ext high", 32'(hi_exp[t]), rv[28]);
      ext_irq_pins_i[0] <= 1'b0;
      repeat (5) @(posedge clock_i);
      rd(PENDING_OFS, rv); chk("ext low", 32'(lo_exp[t]), rv[28]);
    end
    wr(CLEAR_CMD_OFS, 32'h1000_0000);
    $display("test external pin done");
    // fast pin wakes the core; fast vector read clears source 0
    wr(SMR_BASE, md(TRIG_EDGE_RISE, 3'h0));
    wr(ENABLE_CMD_OFS, 32'h1);
    sleep <= 1'b1;
    @(posedge clock_i);
    sleep <= 1'b0;
    fast_irq_pin_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    chk("fast req", 32'h0, fast_req_n_o);
    chk("core woke", 32'h0, core_idle);
    rd(FAST_VECTOR_OFS, rv);
    rd(PENDING_OFS, rv); chk("fast cleared", 32'h0, rv[0]);
    repeat (2) @(posedge clock_i);
    chk("fast req off", 32'h1, fast_req_n_o);
    fast_irq_pin_i <= 1'b0;
    $display("test fast source done");
    // global mask: wake without a normal request
    wr(CONTROL_OFS, 32'h2);
    sleep <= 1'b1;
    @(posedge clock_i);
    sleep <= 1'b0;
    system_source_i <= 8'h01;
    repeat (4) @(posedge clock_i);
    chk("masked req", 32'h1, normal_req_n_o);
    chk("wake", 32'h1, wakeup_o);
    chk("core woke masked", 32'h0, core_idle);
    system_source_i <= 8'h0;
    $display("test global mask done");
    complete_run();
  end
endmodule
